// ===== design/hdlc_fifo_host_interface.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Synchronous FIFO
// ----------------------------------------
module hdlc_sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CW = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ready_q;
  logic valid_q;
  logic push;
  logic pop;

  assign push = in_valid && ready_q;
  assign pop = out_ready && valid_q;
  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem[rd_ptr_q];
  assign count = count_q;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + ONE;
    end else if (pop && !push) begin
      count_d = count_q - ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + AW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + AW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Flags kept in flops so ready and valid are glitch free
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      ready_q <= (count_d != FULL_COUNT);
      valid_q <= (count_d != '0);
    end
  end
endmodule

// ----------------------------------------
// Host interface top
// ----------------------------------------
module hdlc_fifo_host_interface
  import hdlc_fifo_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data_q,
  input wire logic master_hdlc_int_en,
  output logic irq_q,
  input wire logic tx_pop,
  output logic tx_valid,
  output tx_entry_s tx_head,
  input wire logic tx_underrun,
  input wire logic rx_push,
  output logic rx_ready,
  input wire rx_byte_s rx_byte,
  input wire logic rx_abort,
  input wire logic rx_packet_start
);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  logic rd_status;
  logic wr_tx_ctrl;
  assign rd_status = rd_strobe && hit(addr, ADDR_RX_STATUS);
  assign wr_tx_ctrl = wr_strobe && hit(addr, ADDR_TX_CONTROL);

  logic [7:0] hdlc_event_int_enable_q;
  logic [7:0] hdlc_latched_status_q;
  logic [7:0] tx_fifo_data_q;
  logic [7:0] watermark_q;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_event_int_enable_q <= RESET_BYTE;
    end else if (wr_strobe && hit(addr, ADDR_INT_ENABLE)) begin
      hdlc_event_int_enable_q <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_data_q <= RESET_BYTE;
    end else if (wr_strobe && hit(addr, ADDR_TX_DATA)) begin
      tx_fifo_data_q <= wr_data; // Held until control write
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watermark_q <= RESET_BYTE;
    end else if (wr_strobe && hit(addr, ADDR_WATERMARK)) begin
      watermark_q <= wr_data;
    end
  end

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  tx_entry_s tx_in;
  logic [TX_CW-1:0] tx_count;
  logic tx_in_ready;

  always_comb begin
    tx_in.data = tx_fifo_data_q;
    tx_in.msg_end = wr_data[CTRL_MSG_END]; // Message end mark
  end

  // Full FIFO refuses the push, so the entry is dropped
  hdlc_sync_fifo #(
    .WIDTH($bits(tx_entry_s)),
    .DEPTH(TX_DEPTH),
    .CW(TX_CW)
  ) tx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(wr_tx_ctrl), // Data and control pushed as one
    .in_ready(tx_in_ready),
    .in_data(tx_in),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data(tx_head), // Engine shifts data bit 0 first
    .count(tx_count)
  );

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  rx_entry_s rx_in;
  rx_entry_s rx_head;
  logic rx_valid;
  logic [RX_CW-1:0] rx_count;
  logic in_packet_q;
  logic [2:0] pkt_len_q;
  logic rx_accept;

  assign rx_accept = rx_push && rx_ready;

  always_comb begin
    rx_in.data = rx_byte.data;
    rx_in.opening = !in_packet_q; // First byte after a close
    rx_in.closing = rx_byte.last; // Set for good and bad packets
    rx_in.packet_status = rx_byte.packet_status;
    if (rx_byte.last && (pkt_len_q < (MIN_PACKET - 3'h1))) begin
      rx_in.packet_status = PS_TOO_SHORT; // Runt packet
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_packet_q <= 1'b0;
    end else if (rx_accept) begin
      in_packet_q <= !rx_byte.last;
    end
  end

  // Counts bytes of the packet in flight; saturates, only small values matter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pkt_len_q <= '0;
    end else if (rx_accept && rx_byte.last) begin
      pkt_len_q <= '0;
    end else if (rx_accept && (pkt_len_q != MIN_PACKET)) begin
      pkt_len_q <= pkt_len_q + 3'h1;
    end
  end

  // Byte and its status travel as one entry
  hdlc_sync_fifo #(
    .WIDTH($bits(rx_entry_s)),
    .DEPTH(RX_DEPTH),
    .CW(RX_CW)
  ) rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(rx_in),
    .out_valid(rx_valid),
    .out_ready(rd_status), // Only the status read pops
    .out_data(rx_head),
    .count(rx_count)
  );

  // ----------------------------------------
  // Information and status views
  // ----------------------------------------
  logic [7:0] fifo_info;
  logic [3:0] tx_fifo_level;
  logic tx_low;
  logic rx_high;
  logic tx_low_q;
  logic rx_high_q;

  always_comb begin
    tx_fifo_level = tx_count[TX_CW-1:LEVEL_SHIFT] > (TX_CW-LEVEL_SHIFT)'(LEVEL_MAX)
      ? LEVEL_MAX : tx_count[LEVEL_SHIFT+3:LEVEL_SHIFT];
    fifo_info = RESET_BYTE;
    fifo_info[3:0] = tx_fifo_level;
    fifo_info[INFO_TX_EMPTY] = !tx_valid;
    fifo_info[INFO_RX_EMPTY] = !rx_valid;
  end

  assign tx_low = tx_count < (TX_CW'(watermark_q[2:0]) << TX_MARK_SHIFT);
  assign rx_high = rx_count > (RX_CW'(watermark_q[6:4]) << RX_MARK_SHIFT);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_low_q <= 1'b0;
    end else begin
      tx_low_q <= tx_low;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_high_q <= 1'b0;
    end else begin
      rx_high_q <= rx_high;
    end
  end

  // ----------------------------------------
  // Latched events
  // ----------------------------------------
  logic [7:0] events;
  logic [7:0] clear_mask;

  always_comb begin
    events = RESET_BYTE;
    events[EV_TX_END] = (tx_pop && tx_valid && tx_head.msg_end) || tx_underrun;
    events[EV_TX_UNDERRUN] = tx_underrun;
    events[EV_TX_LOW] = tx_low && !tx_low_q;
    events[EV_RX_HIGH] = rx_high && !rx_high_q;
    events[EV_RX_ABORT] = rx_abort;
    events[EV_RX_START] = rx_packet_start;
    events[EV_RX_END] = rx_accept && rx_byte.last;
    events[EV_RX_OVERRUN] = rx_push && !rx_ready;
    clear_mask = (wr_strobe && hit(addr, ADDR_LATCHED_STATUS)) ? wr_data : RESET_BYTE;
  end

  // New event wins over a same-cycle write-1 clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_latched_status_q <= RESET_BYTE;
    end else begin
      hdlc_latched_status_q <= (hdlc_latched_status_q & ~clear_mask) | events;
    end
  end

  // Only latched events feed the request, never the info bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= master_hdlc_int_en
        && |(hdlc_latched_status_q & hdlc_event_int_enable_q);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Status read of an empty FIFO shows a stale entry; host checks the flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= RESET_BYTE;
    end else if (rd_strobe) begin
      case (addr)
        ADDR_LATCHED_STATUS: rd_data_q <= hdlc_latched_status_q;
        ADDR_INT_ENABLE: rd_data_q <= hdlc_event_int_enable_q;
        ADDR_FIFO_INFO: rd_data_q <= fifo_info;
        ADDR_WATERMARK: rd_data_q <= watermark_q;
        ADDR_RX_DATA: rd_data_q <= rx_head.data;
        ADDR_RX_STATUS: rd_data_q <= {4'h0, rx_head.packet_status,
          rx_head.closing, rx_head.opening};
        default: rd_data_q <= READ_FILLER; // Write-only and unmapped
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== design/hdlc_fifo_pkg.sv
package hdlc_fifo_pkg;

  // ----------------------------------------
  // Register port addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_LATCHED_STATUS = 8'h59;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h5a;
  localparam logic [7:0] ADDR_FIFO_INFO = 8'h5b;
  localparam logic [7:0] ADDR_RX_DATA = 8'h5c;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h5d;
  localparam logic [7:0] ADDR_TX_DATA = 8'h5e;
  localparam logic [7:0] ADDR_TX_CONTROL = 8'h5f;
  localparam logic [7:0] ADDR_WATERMARK = 8'h58;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int EV_TX_END = 0;
  localparam int EV_TX_UNDERRUN = 1;
  localparam int EV_TX_LOW = 2;
  localparam int EV_RX_HIGH = 3;
  localparam int EV_RX_ABORT = 4;
  localparam int EV_RX_START = 5;
  localparam int EV_RX_END = 6;
  localparam int EV_RX_OVERRUN = 7;
  localparam int INFO_TX_EMPTY = 4;
  localparam int INFO_RX_EMPTY = 5;
  localparam int CTRL_MSG_END = 0;
  localparam int LEVEL_SHIFT = 4;
  localparam logic [3:0] LEVEL_MAX = 4'hf;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] PS_TOO_SHORT = 2'h2;
  localparam logic [2:0] MIN_PACKET = 3'h4;
  localparam logic [7:0] READ_FILLER = 8'h00;

  // ----------------------------------------
  // Depths and watermark steps
  // ----------------------------------------
  localparam int TX_DEPTH = 256;
  localparam int RX_DEPTH = 32;
  localparam int TX_CW = 9;
  localparam int RX_CW = 6;
  localparam int TX_MARK_SHIFT = 5;
  localparam int RX_MARK_SHIFT = 2;

  typedef struct packed {
    logic msg_end;
    logic [7:0] data;
  } tx_entry_s;

  typedef struct packed {
    logic [1:0] packet_status;
    logic closing;
    logic opening;
    logic [7:0] data;
  } rx_entry_s;

  typedef struct packed {
    logic last;
    logic [1:0] packet_status;
    logic [7:0] data;
  } rx_byte_s;

endpackage

// ===== bench/hdlc_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_host_props
  import hdlc_fifo_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] rd_data_q,
  input wire logic master_hdlc_int_en,
  input wire logic irq_q,
  input wire logic tx_pop,
  input wire logic tx_valid,
  input wire logic rx_push,
  input wire logic rx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // Checks
  // ------------------------------
  irq_master_a: assert property (!master_hdlc_int_en |=> !irq_q)
    else $error("irq with master off");
  irq_cause_a: assert property ($rose(irq_q) |-> $past(master_hdlc_int_en))
    else $error("irq rose without master");
  tx_fill_a: assert property ($rose(tx_valid) |->
    $past(wr_strobe && addr == ADDR_TX_CONTROL))
    else $error("tx entry without control write");
  tx_drain_a: assert property ($fell(tx_valid) |-> $past(tx_pop))
    else $error("tx emptied without pop");
  rx_full_a: assert property ($fell(rx_ready) |-> $past(rx_push))
    else $error("rx filled without push");
  rx_free_a: assert property ($rose(rx_ready) && $past(rst_n) |->
    $past(rd_strobe && addr == ADDR_RX_STATUS))
    else $error("rx freed without status read");
  rx_peek_a: assert property (rd_strobe && addr == ADDR_RX_DATA && !rx_push
    |=> $stable(rx_ready))
    else $error("data read moved rx fifo");
  rd_hold_a: assert property (!rd_strobe |=> $stable(rd_data_q))
    else $error("read data moved without read");
  tx_filler_a: assert property (rd_strobe && (addr == ADDR_TX_DATA ||
    addr == ADDR_TX_CONTROL) |=> rd_data_q == READ_FILLER)
    else $error("tx register read not filler");
  info_empty_a: assert property (rd_strobe && addr == ADDR_FIFO_INFO |=>
    rd_data_q[INFO_TX_EMPTY] == !$past(tx_valid))
    else $error("tx empty flag wrong");
  cover property (tx_pop && tx_valid);
  cover property ($rose(irq_q));
  cover property (rd_strobe && addr == ADDR_RX_STATUS);
  cover property ($fell(rx_ready));
endmodule
bind hdlc_fifo_host_interface hdlc_host_props props (.clock(clock), .rst_n(rst_n),
  .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .rd_data_q(rd_data_q),
  .master_hdlc_int_en(master_hdlc_int_en), .irq_q(irq_q), .tx_pop(tx_pop),
  .tx_valid(tx_valid), .rx_push(rx_push), .rx_ready(rx_ready));
`default_nettype wire

// ===== bench/hdlc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_host_model
  import hdlc_fifo_pkg::*;
(
  input wire logic clock,
  output logic [7:0] addr,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data_q
);
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clock);
    addr = a;
    wr_data = d;
    rd_strobe = !w;
    wr_strobe = w;
    @(negedge clock);
    q = rd_data_q;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    // Released bus must not look like a held value
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    access(1'b0, a, 8'h00, q);
  endtask
  task automatic push(input logic [7:0] d, input logic last);
    wr(ADDR_TX_DATA, d);
    wr(ADDR_TX_CONTROL, {7'h00, last});
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import hdlc_fifo_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic rd_strobe, wr_strobe, irq_q, tx_valid, rx_ready;
  logic master_hdlc_int_en = 1'b0;
  logic tx_pop = 1'b0, tx_underrun = 1'b0, rx_push = 1'b0;
  logic rx_abort = 1'b0, rx_packet_start = 1'b0;
  logic [7:0] addr, wr_data, rd_data_q;
  tx_entry_s tx_head;
  rx_byte_s rx_byte = '0;
  int compares = 0;
  int miscompares = 0;
  logic [7:0] ed [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  logic [7:0] es [8] = '{8'h01, 8'h00, 8'h0a, 8'h0b, 8'h01, 8'h00, 8'h00, 8'h06};
  always #25 clock = ~clock;
  hdlc_fifo_host_interface dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_data_q(rd_data_q), .master_hdlc_int_en(master_hdlc_int_en), .irq_q(irq_q),
    .tx_pop(tx_pop), .tx_valid(tx_valid), .tx_head(tx_head), .tx_underrun(tx_underrun),
    .rx_push(rx_push), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_abort(rx_abort),
    .rx_packet_start(rx_packet_start));
  hdlc_host_model host (.clock(clock), .addr(addr), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data_q(rd_data_q));
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.rd(a, q);
    check(q, e);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge clock);
    check({7'h00, irq_q}, {7'h00, e});
  endtask
  // Order: tx_pop, tx_underrun, rx_abort, rx_packet_start, rx_push
  task automatic eng(input logic [4:0] m);
    @(negedge clock);
    {tx_pop, tx_underrun, rx_abort, rx_packet_start, rx_push} = m;
    @(negedge clock);
    {tx_pop, tx_underrun, rx_abort, rx_packet_start, rx_push} = 5'h00;
  endtask
  task automatic rxb(input logic [7:0] d, input logic last, input logic [1:0] ps);
    rx_byte = {last, ps, d};
    eng(5'h01);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    rd_chk(ADDR_FIFO_INFO, 8'h30);
    host.wr(ADDR_INT_ENABLE, 8'hff);
    master_hdlc_int_en = 1'b1;
    irq_chk(1'b0);
  endtask
  task automatic t_tx();
    host.push(8'ha5, 1'b0);
    host.push(8'h3c, 1'b1);
    @(negedge clock);
    check(tx_head.data, 8'ha5);
    check({7'h00, tx_head.msg_end}, 8'h00);
    rd_chk(ADDR_FIFO_INFO, 8'h20);
    rd_chk(ADDR_TX_DATA, READ_FILLER);
    rd_chk(ADDR_TX_CONTROL, READ_FILLER);
    eng(5'h10);
    check({7'h00, tx_head.msg_end}, 8'h01);
    eng(5'h10);
    rd_chk(ADDR_LATCHED_STATUS, 8'h01);
    irq_chk(1'b1);
    host.wr(ADDR_INT_ENABLE, 8'hfe);
    irq_chk(1'b0);
    host.wr(ADDR_INT_ENABLE, 8'hff);
    irq_chk(1'b1);
    master_hdlc_int_en = 1'b0;
    irq_chk(1'b0);
    master_hdlc_int_en = 1'b1;
    host.wr(ADDR_LATCHED_STATUS, 8'h01);
    irq_chk(1'b0);
  endtask
  task automatic t_underrun();
    eng(5'h08);
    rd_chk(ADDR_LATCHED_STATUS, 8'h03);
    host.wr(ADDR_LATCHED_STATUS, 8'h02);
    rd_chk(ADDR_LATCHED_STATUS, 8'h01);
    host.wr(ADDR_LATCHED_STATUS, 8'h01);
  endtask
  task automatic t_rx();
    // Short packets are flagged too short whatever the engine reports
    for (int i = 0; i < 8; i++) begin
      rxb(ed[i], (i == 2 || i == 3 || i == 7), (i == 7) ? 2'h1 : 2'h0);
    end
    rd_chk(ADDR_FIFO_INFO, 8'h10);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ADDR_RX_DATA, ed[i]);
      rd_chk(ADDR_RX_DATA, ed[i]);
      rd_chk(ADDR_RX_STATUS, es[i]);
    end
    rd_chk(ADDR_FIFO_INFO, 8'h30);
    host.wr(ADDR_LATCHED_STATUS, 8'hff);
    host.wr(ADDR_INT_ENABLE, 8'hef);
    eng(5'h04);
    irq_chk(1'b0);
    host.wr(ADDR_INT_ENABLE, 8'h10);
    irq_chk(1'b1);
    host.wr(ADDR_LATCHED_STATUS, 8'hff);
    irq_chk(1'b0);
  endtask
  task automatic t_over();
    host.wr(ADDR_WATERMARK, 8'h11);
    eng(5'h02);
    for (int i = 0; i < 33; i++) rxb(i[7:0], 1'b0, 2'h0);
    check({7'h00, rx_ready}, 8'h00);
    rd_chk(ADDR_LATCHED_STATUS, 8'hac);
    for (int i = 0; i < 32; i++) begin
      rd_chk(ADDR_RX_DATA, i[7:0]);
      rd_chk(ADDR_RX_STATUS, (i == 0) ? 8'h01 : 8'h00);
      check({7'h00, rx_ready}, 8'h01);
    end
    rd_chk(ADDR_FIFO_INFO, 8'h30);
    host.wr(ADDR_LATCHED_STATUS, 8'hff);
  endtask
  task automatic t_full();
    for (int i = 0; i < 256; i++) begin
      host.push(i[7:0], 1'b0);
      if (i == 15) rd_chk(ADDR_FIFO_INFO, 8'h21);
    end
    rd_chk(ADDR_FIFO_INFO, 8'h2f);
    host.push(8'hee, 1'b1);
    for (int i = 0; i < 255; i++) eng(5'h10);
    check(tx_head.data, 8'hff);
    eng(5'h10);
    check({7'h00, tx_valid}, 8'h00);
  endtask
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_tx();
    t_underrun();
    t_rx();
    t_over();
    t_full();
    conclude();
  end
  // Full run is about 1900 cycles; allow ample margin
  initial begin
    #(50 * 20000);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
